// *** flip_chk.sv ***
// checker: apb answer, pending bit placement, wake
// assumes bind onto flip_controller
`timescale 1ns/1ps
`default_nettype none
module flip_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rtc_alarm_status,
    input wire logic [27:0] gpio_edge_status,
    input wire logic idle_mode,
    input wire logic wake_request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic acc = psel && penable;
    wire logic rdp = acc && !pwrite && paddr == flip_pkg::flip_off_pending;
    AST_READY: assert property (acc |-> pready) else $error("no ready");
    AST_SLVERR: assert property (acc && paddr > flip_pkg::flip_off_int_clear |-> pslverr)
        else $error("no err");
    AST_MAPPED: assert property (acc && paddr <= flip_pkg::flip_off_int_clear
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("spurious err");
    AST_UNMAP_ZERO: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped data");
    AST_RTC_BIT: assert property (rdp |-> prdata[31] == $past(rtc_alarm_status, 2))
        else $error("bit 31");
    AST_GPIO_OR: assert property (rdp |-> prdata[11] == |$past(gpio_edge_status[27:11], 2))
        else $error("bit 11");
    AST_GPIO_DIRECT: assert property (rdp |-> prdata[10:0] == $past(gpio_edge_status[10:0], 2))
        else $error("bits 10..0");
    AST_WAKE: assert property (idle_mode && $past(rtc_alarm_status) && !$past(rst) |-> wake_request)
        else $error("no wake");
    AST_AWAKE: assert property (!idle_mode |-> !wake_request) else $error("wake");
    cover property (rdp && prdata[31]);
    cover property (wake_request);
    cover property (acc && pslverr);
endmodule // flip_chk
bind flip_controller flip_chk u_chk (
    .core_clk(core_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rtc_alarm_status(rtc_alarm_status),
    .gpio_edge_status(gpio_edge_status),
    .idle_mode(idle_mode),
    .wake_request(wake_request)
);
`default_nettype wire

// *** flip_controller.sv ***
// first-level interrupt pending collector with apb registers
// assumes source units hold status until software clears them at the source
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module flip_controller (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rtc_alarm_status,
    input wire logic rtc_tick_status,
    input wire logic [3:0] os_timer_match_status,
    input wire logic [17:0] dma_status,
    input wire logic [2:0] ssp_status,
    input wire logic [7:0] codec_status,
    input wire logic [5:0] uart3_status,
    input wire logic [11:0] uart2_high_speed_serial_port_status,
    input wire logic [5:0] uart1_status,
    input wire logic [4:0] sdlc_status,
    input wire logic [5:0] usb_status,
    input wire logic [11:0] lcd_status,
    input wire logic [27:0] gpio_edge_status,
    input wire logic idle_mode,
    output logic core_irq,
    output logic core_fiq,
    output logic wake_request,
    output logic ctrl_irq
);
    import flip_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // request collection
    // every source line is a level held by its unit until software
    // clears it there; nothing here remembers a request by itself

    logic [31:0] raw_req;
    logic [5:0] dma_req;
    logic ssp_req;
    logic codec_req;
    logic uart3_req;
    logic uart2_req;
    logic uart1_req;
    logic sdlc_req;
    logic usb_req;
    logic lcd_req;
    logic gpio_upper_req;
    logic [31:0] pending_reg;

    genvar ch;
    generate
        for (ch = 0; ch < 6; ch++) begin : g_dma
            // R7 dma channel or
            flip_source_or #(.width(3)) u_or (
                .status(dma_status[ch*3 +: 3]),
                .request(dma_req[ch])
            );
        end
    endgenerate

    // R8 one reducer per unit
    flip_source_or #(.width(3)) u_ssp_or (
        .status(ssp_status),
        .request(ssp_req)
    );

    flip_source_or #(.width(8)) u_codec_or (
        .status(codec_status),
        .request(codec_req)
    );

    flip_source_or #(.width(6)) u_uart3_or (
        .status(uart3_status),
        .request(uart3_req)
    );

    // uart and high-speed halves of port 2 share one bit
    flip_source_or #(.width(12)) u_uart2_or (
        .status(uart2_high_speed_serial_port_status),
        .request(uart2_req)
    );

    flip_source_or #(.width(6)) u_uart1_or (
        .status(uart1_status),
        .request(uart1_req)
    );

    flip_source_or #(.width(5)) u_sdlc_or (
        .status(sdlc_status),
        .request(sdlc_req)
    );

    flip_source_or #(.width(6)) u_usb_or (
        .status(usb_status),
        .request(usb_req)
    );

    flip_source_or #(.width(12)) u_lcd_or (
        .status(lcd_status),
        .request(lcd_req)
    );

    // R9 upper pins share bit
    flip_source_or #(.width(17)) u_gpio_or (
        .status(gpio_edge_status[27:11]),
        .request(gpio_upper_req)
    );

    always_comb begin
        raw_req = 32'h0000_0000;
        // R5 rtc bits
        raw_req[flip_bit_rtc_alarm] = rtc_alarm_status;
        raw_req[flip_bit_rtc_tick] = rtc_tick_status;
        // R6 os timer bits
        raw_req[flip_bit_ost_lo +: 4] = os_timer_match_status;
        raw_req[flip_bit_dma_lo +: 6] = dma_req;
        // R8 unit bits
        raw_req[flip_bit_ssp] = ssp_req;
        raw_req[flip_bit_codec] = codec_req;
        raw_req[flip_bit_uart3] = uart3_req;
        raw_req[flip_bit_uart2] = uart2_req;
        raw_req[flip_bit_uart1] = uart1_req;
        raw_req[flip_bit_sdlc] = sdlc_req;
        raw_req[flip_bit_usb] = usb_req;
        raw_req[flip_bit_lcd] = lcd_req;
        // R9 gpio bits
        raw_req[flip_bit_gpio_hi] = gpio_upper_req;
        raw_req[10:0] = gpio_edge_status[10:0];
    end

    // R16 level sampling
    // one flop stage here; with the setup capture of prdata, a read may lag a line change by two cycles
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pending_reg <= 32'h0000_0000;
        end else begin
            pending_reg <= raw_req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // delivery

    logic [31:0] mask_reg;
    logic [31:0] routing_reg;
    logic [31:0] active;
    logic [31:0] irq_pending_vector;
    logic [31:0] fiq_pending_vector;

    // idle lets any request through so the chip can resume
    // R12 mask gates delivery; R14 idle bypasses it
    assign active = idle_mode ? pending_reg : (pending_reg & mask_reg);
    // routing one sends a source to the fiq side
    // R13 routing split; R11 single-source bits read directly
    assign irq_pending_vector = active & ~routing_reg;
    assign fiq_pending_vector = active & routing_reg;
    assign core_irq = |irq_pending_vector;
    assign core_fiq = |fiq_pending_vector;
    // R14 wake on any request
    assign wake_request = idle_mode & (|pending_reg);

    ////////////////////////////////////////////////////////////////////
    // apb decode
    // zero wait states: every access ends in its first access cycle

    logic wr_en;
    logic rd_setup;
    logic sel_irq;
    logic sel_fiq;
    logic sel_mask;
    logic sel_routing;
    logic sel_pending;
    logic sel_status;
    logic sel_enable;
    logic sel_clear;
    logic hit;
    logic [31:0] rd_mux;
    logic [1:0] int_status_reg;
    logic [1:0] int_enable_reg;

    assign wr_en = psel & penable & pwrite;
    // read data captured in setup so it stands through the access
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;

    // full byte address compare, so misaligned offsets miss
    // R1 register set
    assign sel_irq = (paddr == flip_off_irq_pending);
    assign sel_fiq = (paddr == flip_off_fiq_pending);
    assign sel_mask = (paddr == flip_off_mask);
    assign sel_routing = (paddr == flip_off_routing);
    assign sel_pending = (paddr == flip_off_pending);
    assign sel_status = (paddr == flip_off_int_status);
    assign sel_enable = (paddr == flip_off_int_enable);
    assign sel_clear = (paddr == flip_off_int_clear);
    assign hit = sel_irq | sel_fiq | sel_mask | sel_routing |
                 sel_pending | sel_status | sel_enable | sel_clear;

    // unmapped addresses answer with an error
    assign pslverr = psel & penable & ~hit;

    ////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            flip_off_irq_pending: rd_mux = irq_pending_vector;
            flip_off_fiq_pending: rd_mux = fiq_pending_vector;
            flip_off_mask: rd_mux = mask_reg;
            flip_off_routing: rd_mux = routing_reg;
            // R3 combined vector; R4 unmasked
            flip_off_pending: rd_mux = pending_reg;
            flip_off_int_status: rd_mux = {30'h0, int_status_reg};
            flip_off_int_enable: rd_mux = {30'h0, int_enable_reg};
            // clear register is write only and reads back zero
            flip_off_int_clear: rd_mux = 32'h0000_0000;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // writes leave the last read data standing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // mask and routing
    // R2 software initialises these
    // zero reset keeps delivery off outside idle mode until software sets masks

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_reg <= flip_mask_reset;
        end else if (wr_en & sel_mask) begin
            mask_reg <= pwdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            routing_reg <= flip_routing_reset;
        end else if (wr_en & sel_routing) begin
            routing_reg <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // block interrupt: sticky events on core_irq / core_fiq rising

    logic [1:0] line_now;
    logic [1:0] line_d_reg;
    logic [1:0] rise;
    logic [1:0] clr;

    always_comb begin
        line_now = 2'h0;
        line_now[flip_ev_irq] = core_irq;
        line_now[flip_ev_fiq] = core_fiq;
    end

    assign rise = line_now & ~line_d_reg;
    // write one clears; a rise in the same cycle still wins
    assign clr = (wr_en & sel_clear) ? pwdata[1:0] : 2'h0;

    // resets low like both lines, so no false rise after reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_d_reg <= 2'h0;
        end else begin
            line_d_reg <= line_now;
        end
    end

    // set wins over clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_status_reg <= flip_int_reset;
        end else begin
            int_status_reg <= (int_status_reg & ~clr) | rise;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_enable_reg <= flip_int_reset;
        end else if (wr_en & sel_enable) begin
            int_enable_reg <= pwdata[1:0];
        end
    end

    // level output, held until software clears the status bit or its enable bit
    assign ctrl_irq = |(int_status_reg & int_enable_reg);

endmodule // flip_controller
`default_nettype wire

// *** flip_pkg.sv ***
// package for the first-level interrupt pending collector
// assumes an apb slave at 32-bit data, one aligned word per register
//
// Contract
// R1: four software registers: irq pending, fiq pending, mask, routing.
// R2: software programs mask and routing before enabling core interrupts.
// R3: combined pending vector is 32 bits, read only, one bit per source.
// R4: pending bits ignore the mask; masking only gates delivery.
// R5: bit 31 rtc alarm match, bit 30 rtc one-second tick.
// R6: bits 29..26 os timer matches 3,2,1,0.
// R7: bits 25..20 dma channels 5..0, three sources each.
// R8: bits 19..12 ssp, codec, uart3, uart2/high_speed_serial_port, uart1, sdlc, usb, display.
// R9: bit 11 ors pin edges 27..11; bits 10..0 follow same-numbered pins.
// R10: handler reads controller, then unit status, for multi-source bits.
// R11: single-source bits are identified by controller registers alone.
// R12: a pending request reaches the core only when its mask bit is one.
// R13: routing bit picks fiq (one) or irq (zero) per source.
// R14: in idle mode masks are ignored; any request raises wake.
// R15: each pending bit is the or of source status bits, cleared at source.
// R16: pending bits are levels, sampled each clock, no latching.
package flip_pkg;
    localparam int unsigned flip_src_count = 32;
    localparam logic [11:0] flip_off_irq_pending = 12'h000;
    localparam logic [11:0] flip_off_mask = 12'h004;
    localparam logic [11:0] flip_off_routing = 12'h008;
    localparam logic [11:0] flip_off_pending = 12'h00c;
    localparam logic [11:0] flip_off_fiq_pending = 12'h010;
    localparam logic [11:0] flip_off_int_status = 12'h014;
    localparam logic [11:0] flip_off_int_enable = 12'h018;
    localparam logic [11:0] flip_off_int_clear = 12'h01c;
    localparam logic [31:0] flip_mask_reset = 32'h0000_0000;
    localparam logic [31:0] flip_routing_reset = 32'h0000_0000;
    localparam logic [1:0] flip_int_reset = 2'h0;
    localparam int unsigned flip_bit_rtc_alarm = 31;
    localparam int unsigned flip_bit_rtc_tick = 30;
    localparam int unsigned flip_bit_ost_lo = 26;
    localparam int unsigned flip_bit_dma_lo = 20;
    localparam int unsigned flip_bit_ssp = 19;
    localparam int unsigned flip_bit_codec = 18;
    localparam int unsigned flip_bit_uart3 = 17;
    localparam int unsigned flip_bit_uart2 = 16;
    localparam int unsigned flip_bit_uart1 = 15;
    localparam int unsigned flip_bit_sdlc = 14;
    localparam int unsigned flip_bit_usb = 13;
    localparam int unsigned flip_bit_lcd = 12;
    localparam int unsigned flip_bit_gpio_hi = 11;
    localparam int unsigned flip_ev_irq = 0;
    localparam int unsigned flip_ev_fiq = 1;
endpackage

// *** flip_source_or.sv ***
// reduces grouped second-level status lines to one request bit per group (unit, dma channel or upper gpio pins)
// assumes status lines are synchronous levels from the source units
`timescale 1ns/1ps
`default_nettype none
module flip_source_or #(
    parameter int unsigned width = 3
) (
    input wire logic [width-1:0] status,
    output logic request
);
    // R15 or of status
    assign request = |status;
endmodule // flip_source_or
`default_nettype wire

// *** flip_src_model.sv ***
// source-unit model: sticky second-level status bits
// assumes the bench pulses set and clear vectors for one cycle
`timescale 1ns/1ps
`default_nettype none
module flip_src_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [109:0] raise,
    input wire logic [109:0] clr,
    output logic [109:0] st_reg
);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) st_reg <= '0;
        else st_reg <= (st_reg & ~clr) | raise;
    end
endmodule // flip_src_model
`default_nettype wire

// *** testbench.sv ***
// random-source bench for flip_controller
// assumes flip_src_model drives the status lines
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flip_pkg::*;
    logic core_clk = 0, rst, psel = 0, penable = 0, pwrite = 0, idle_mode = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, core_irq, core_fiq, wake_request, ctrl_irq, rtc_alarm_status;
    logic rtc_tick_status;
    logic [3:0] os_timer_match_status;
    logic [17:0] dma_status;
    logic [2:0] ssp_status;
    logic [7:0] codec_status;
    logic [5:0] uart3_status, uart1_status, usb_status;
    logic [11:0] uart2_high_speed_serial_port_status, lcd_status;
    logic [4:0] sdlc_status;
    logic [27:0] gpio_edge_status;
    logic [109:0] raise = '0, clr = '0, st;
    int n_mismatch = 0, cmp_count = 0, seed = 32'h28175635;
    assign {rtc_alarm_status, rtc_tick_status, os_timer_match_status, dma_status, ssp_status,
        codec_status, uart3_status, uart2_high_speed_serial_port_status, uart1_status, sdlc_status, usb_status,
        lcd_status, gpio_edge_status} = st;
    always #10 core_clk = ~core_clk;
    flip_src_model u_src (.core_clk, .rst, .raise, .clr, .st_reg(st));
    flip_controller dut (.*);
    ////////////////////////////////////////
    function automatic logic [31:0] pend(input logic [109:0] s);
        logic [31:0] p;
        p[31:26] = s[109:104];
        for (int n = 0; n < 6; n++) p[20+n] = |s[86+3*n+:3];
        p[19:11] = {|s[85:83], |s[82:75], |s[74:69], |s[68:57], |s[56:51], |s[50:46],
            |s[45:40], |s[39:28], |s[27:11]};
        p[10:0] = s[10:0];
        return p;
    endfunction
    function automatic logic [109:0] rnd();
        logic [127:0] v;
        v = {$random(seed), $random(seed), $random(seed), $random(seed)};
        return v[109:0];
    endfunction
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int i;
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            wrap_up;
        end
        r = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1, a, d, r);
        // the write lands in this edge's update; look at levels later
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(0, a, 0, r);
        chk(r, e);
    endtask
    task automatic src(input logic [109:0] s, input logic [109:0] c);
        raise <= s;
        clr <= c;
        @(posedge core_clk);
        raise <= '0;
        clr <= '0;
        repeat (3) @(posedge core_clk);
    endtask
    ////////////////////////////////////////
    initial begin
        logic [109:0] s;
        logic [31:0] m, rt, p, me;
        logic idl;
        rst = 1;
        repeat (12) @(posedge core_clk);
        rst <= 0;
        rd(flip_off_mask, 32'h0);
        rd(flip_off_routing, 32'h0);
        wr(flip_off_pending, 32'hffff_ffff);
        rd(flip_off_pending, 32'h0);
        wr(12'h020, 32'hffff_ffff);
        rd(12'h020, 32'h0);
        $display("test registers done");
        for (int k = 0; k < 24; k++) begin
            s = k == 0 ? '1 : rnd() & rnd();
            m = $random(seed);
            rt = $random(seed);
            idl = k % 4 == 3;
            idle_mode <= idl;
            src(s, '1);
            wr(flip_off_mask, m);
            wr(flip_off_routing, rt);
            p = pend(s);
            me = idl ? '1 : m;
            rd(flip_off_pending, p);
            rd(flip_off_pending, pend(st));
            rd(flip_off_irq_pending, p & me & ~rt);
            rd(flip_off_fiq_pending, p & me & rt);
            chk(32'(core_irq), 32'(|(p & me & ~rt)));
            chk(32'(core_fiq), 32'(|(p & me & rt)));
            chk(32'(wake_request), 32'(idl & |p));
            s[k*4+1] = 1'b0;
            src('0, 110'(1) << (k*4+1));
            rd(flip_off_pending, pend(s));
        end
        $display("test pending done");
        idle_mode <= 0;
        src('0, '1);
        wr(flip_off_mask, 32'hffff_ffff);
        wr(flip_off_routing, 32'h0);
        wr(flip_off_int_enable, 32'h3);
        wr(flip_off_int_clear, 32'h3);
        rd(flip_off_int_status, 32'h0);
        chk(32'(ctrl_irq), 32'h0);
        src(110'(1) << 109, '0);
        rd(flip_off_int_status, 32'h1);
        chk(32'(ctrl_irq), 32'h1);
        wr(flip_off_int_enable, 32'h2);
        chk(32'(ctrl_irq), 32'h0);
        wr(flip_off_int_enable, 32'h3);
        wr(flip_off_int_clear, 32'h1);
        rd(flip_off_int_status, 32'h0);
        chk(32'(ctrl_irq), 32'h0);
        wr(flip_off_routing, 32'h8000_0000);
        rd(flip_off_int_status, 32'h2);
        chk(32'(ctrl_irq), 32'h1);
        chk(32'(core_fiq), 32'h1);
        $display("test interrupt done");
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
